// ===== rtl/vfd_ctrl_pkg.sv
package vfd_ctrl_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] MODE_SELECT_IDX   = 16'hffa0;
   localparam logic [15:0] DIGIT_CUT_IDX     = 16'hffa1;
   localparam logic [15:0] MASK_COUNT_IDX    = 16'hffa2;
   localparam int          ADDR_W            = 18;

   // Reset values
   localparam logic [7:0]  MODE_SELECT_RST   = 8'h00;
   localparam logic [7:0]  DIGIT_CUT_RST     = 8'h00;
   localparam logic [5:0]  MASK_COUNT_RST    = 6'h00;

   // Mode select fields
   localparam int          SEG_FIELD_LSB     = 0;
   localparam int          SEG_FIELD_W       = 5;
   localparam int          MODE_BIT          = 5;
   localparam int          NOISE_BIT         = 6;
   localparam int          SCAN_FLAG_BIT     = 7;
   localparam logic [5:0]  SEG_BASE          = 6'h09;

   // Digit/cut/cycle fields
   localparam int          CYCLE_BIT         = 0;
   localparam int          CUT_FIELD_LSB     = 1;
   localparam int          CUT_FIELD_W       = 3;
   localparam int          DIGIT_FIELD_LSB   = 4;
   localparam int          DIGIT_FIELD_W     = 4;

   // Mask count field
   localparam int          MASK_FIELD_W      = 6;
   localparam logic [5:0]  MASK_MAX          = 6'h27;

   // Display cycle lengths in main-clock periods
   localparam logic [11:0] CYCLE_SHORT       = 12'h400;
   localparam logic [11:0] CYCLE_LONG        = 12'h800;
   // Log2 of half of one sixteenth of a short cycle, in clocks
   localparam int          HALF_SIXTEENTH_SH = 5;

   localparam int          NUM_OUTPUTS_DEF   = 53;

   typedef enum logic [1:0] {
      PH_STOPPED,
      PH_DISPLAY,
      PH_KEYSCAN
   } phase_e;
endpackage

// ===== rtl/vfd_display_mode_control.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module vfd_display_mode_control
   import vfd_ctrl_pkg::*;
#(
   parameter int NUM_OUTPUTS = NUM_OUTPUTS_DEF
) (
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 sys_rst_in,
   // Avalon-MM slave
   input  wire logic [ADDR_W-1:0]    avs_address_in,
   input  wire logic                 avs_read_in,
   input  wire logic                 avs_write_in,
   input  wire logic [31:0]          avs_writedata_in,
   input  wire logic [3:0]           avs_byteenable_in,
   output logic      [31:0]          avs_readdata_out,
   output logic                      avs_waitrequest_out,
   // Display memory write check
   input  wire logic [5:0]           bit_index_in,
   output logic                      bit_protected_out,
   // Display timing
   output logic [15:0]               grid_out,
   output logic [4:0]                slot_index_out,
   output logic                      segment_window_out,
   output logic                      scan_phase_flag_out,
   output logic                      key_scan_start_out,
   output logic                      display_active_out,
   output logic                      mode_select_bit_out,
   // Output allocation
   output logic [5:0]                digit_outputs_out,
   output logic [5:0]                segment_outputs_out,
   // Noise eliminator
   output logic                      noise_filter_range_out,
   output logic                      noise_filter_enable_out
);

   // Elaboration check: six-bit output counts and the 16-digit, 40-segment range
   if (NUM_OUTPUTS < 18 || NUM_OUTPUTS > 63) begin
      $error("NUM_OUTPUTS must lie in 18..63");
   end

   localparam logic [5:0] NUM_OUT_C = 6'(NUM_OUTPUTS);

   typedef struct packed {
      logic [6:0]  mode_select;
      logic [7:0]  digit_cut;
      logic [5:0]  mask_count;
      phase_e      phase;
      logic [11:0] cyc_cnt;
      logic [4:0]  slot;
      logic        ack;
      logic [31:0] rdata;
      logic        prot;
      logic [15:0] grid;
      logic        window;
      logic        ks_start;
      logic [5:0]  digits;
      logic [5:0]  segs;
   } state_s;

   state_s state_reg;
   state_s state_next;

   logic [15:0]  word_idx;
   logic         addr_ok;
   logic         req;
   logic [3:0]   dig_code;
   logic [4:0]   dig_count;
   logic [11:0]  cyc_len;
   logic [3:0]   sixteenths;
   logic [11:0]  cut_half;
   logic [5:0]   seg_total;
   logic [5:0]   seg_room;
   logic         running;

   assign word_idx = avs_address_in[ADDR_W-1:2];
   assign addr_ok  = (avs_address_in[1:0] == 2'b00);
   assign req      = avs_read_in | avs_write_in;

   // Answer one cycle after the request is seen
   assign avs_waitrequest_out = req & ~state_reg.ack;

   always_comb begin
      state_next          = state_reg;
      state_next.ack      = req & ~state_reg.ack;
      state_next.ks_start = 1'b0;

      // Register writes; partial-byte writes are ignored
      // whole byte required
      if (avs_write_in && !state_reg.ack && addr_ok && avs_byteenable_in[0]) begin
         unique case (word_idx)
            MODE_SELECT_IDX: begin
               state_next.mode_select = avs_writedata_in[6:0];
            end
            DIGIT_CUT_IDX: begin
               state_next.digit_cut = avs_writedata_in[7:0];
            end
            MASK_COUNT_IDX: begin
               if (avs_writedata_in[5:0] <= MASK_MAX && avs_writedata_in[7:6] == 2'b00) begin
                  state_next.mask_count = avs_writedata_in[5:0];
               end
            end
            default: begin
            end
         endcase
      end

      // Read data; unmapped words read as zero
      state_next.rdata = 32'h0000_0000;
      if (avs_read_in && !state_reg.ack && addr_ok) begin
         unique case (word_idx)
            MODE_SELECT_IDX: begin
               state_next.rdata[7:0] = {(state_reg.phase == PH_KEYSCAN), state_reg.mode_select};
            end
            DIGIT_CUT_IDX: begin
               state_next.rdata[7:0] = state_reg.digit_cut;
            end
            MASK_COUNT_IDX: begin
               state_next.rdata[7:0] = {2'b00, state_reg.mask_count};
            end
            default: begin
            end
         endcase
      end
   end

   // Settings decoded from current register contents
   always_comb begin
      dig_code  = state_reg.digit_cut[DIGIT_FIELD_LSB +: DIGIT_FIELD_W];
      // code n gives n plus 1 digits; code 0 stops the display
      dig_count = {1'b0, dig_code} + 5'h01;
      running   = (dig_code != 4'h0);
      cyc_len   = state_reg.digit_cut[CYCLE_BIT] ? CYCLE_LONG : CYCLE_SHORT;
      // cut table, 1 then even sixteenths
      if (state_reg.digit_cut[CUT_FIELD_LSB +: CUT_FIELD_W] == 3'h0) begin
         sixteenths = 4'h1;
      end else begin
         sixteenths = {state_reg.digit_cut[CUT_FIELD_LSB +: CUT_FIELD_W], 1'b0};
      end
      // Half the cut at each end of the period
      cut_half  = 12'(sixteenths) << (HALF_SIXTEENTH_SH + int'(state_reg.digit_cut[CYCLE_BIT]));
      seg_total = SEG_BASE + {1'b0, state_reg.mode_select[SEG_FIELD_LSB +: SEG_FIELD_W]};
      // digits first, segments get the rest
      seg_room  = NUM_OUT_C - {1'b0, dig_count};
   end

   logic [11:0] cnt_n;
   logic [4:0]  slot_n;
   phase_e      phase_n;
   logic        ks_n;

   // Display period sequencer
   always_comb begin
      cnt_n   = state_reg.cyc_cnt;
      slot_n  = state_reg.slot;
      phase_n = state_reg.phase;
      ks_n    = 1'b0;
      if (!running) begin
         cnt_n   = 12'h000;
         slot_n  = 5'h00;
         phase_n = PH_STOPPED;
      end else if (state_reg.phase == PH_STOPPED) begin
         cnt_n   = 12'h000;
         slot_n  = 5'h00;
         phase_n = PH_DISPLAY;
      end else if (state_reg.cyc_cnt >= cyc_len - 12'h001) begin
         cnt_n = 12'h000;
         if (state_reg.phase == PH_KEYSCAN) begin
            slot_n  = 5'h00;
            phase_n = PH_DISPLAY;
         end else if (state_reg.slot + 5'h01 >= dig_count) begin
            // Key scan slot follows the last digit
            slot_n  = state_reg.slot + 5'h01;
            phase_n = PH_KEYSCAN;
            ks_n    = 1'b1;
         end else begin
            slot_n = state_reg.slot + 5'h01;
         end
      end else begin
         cnt_n = state_reg.cyc_cnt + 12'h001;
      end
   end

   // Timing outputs and write protection, registered
   logic        win_n;
   logic [15:0] grid_n;

   always_comb begin
      win_n  = (state_reg.phase == PH_DISPLAY)
               && (state_reg.cyc_cnt >= cut_half)
               && (state_reg.cyc_cnt < cyc_len - cut_half);
      grid_n = 16'h0000;
      // mode 1 drives grids from the slot counter
      if (win_n && !state_reg.mode_select[MODE_BIT]) begin
         grid_n = 16'h0001 << state_reg.slot[3:0];
      end
   end

   state_s state_fin;

   always_comb begin
      state_fin          = state_next;
      state_fin.cyc_cnt  = cnt_n;
      state_fin.slot     = slot_n;
      state_fin.phase    = phase_n;
      state_fin.ks_start = ks_n;
      state_fin.window   = win_n;
      state_fin.grid     = grid_n;
      state_fin.digits   = running ? {1'b0, dig_count} : 6'h00;
      state_fin.segs     = !running ? 6'h00 : (seg_total > seg_room) ? seg_room : seg_total;
      // protected only in mode 2 while displaying
      // count from the first output bit upward
      state_fin.prot     = state_reg.mode_select[MODE_BIT] && running
                           && (bit_index_in < state_reg.mask_count)
                           && (bit_index_in < seg_total);
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_reg             <= '0;
         state_reg.mode_select <= MODE_SELECT_RST[6:0];
         state_reg.digit_cut   <= DIGIT_CUT_RST;
         state_reg.mask_count  <= MASK_COUNT_RST;
         state_reg.phase       <= PH_STOPPED;
      end else begin
         state_reg <= state_fin;
      end
   end

   assign avs_readdata_out       = state_reg.rdata;
   assign bit_protected_out      = state_reg.prot;
   assign grid_out               = state_reg.grid;
   assign slot_index_out         = state_reg.slot;
   assign segment_window_out     = state_reg.window;
   assign scan_phase_flag_out    = (state_reg.phase == PH_KEYSCAN);
   assign key_scan_start_out     = state_reg.ks_start;
   assign display_active_out     = (state_reg.phase != PH_STOPPED);
   assign mode_select_bit_out    = state_reg.mode_select[MODE_BIT];
   assign digit_outputs_out      = state_reg.digits;
   assign segment_outputs_out    = state_reg.segs;
   // range bit out, filter gated by display activity
   assign noise_filter_range_out  = state_reg.mode_select[NOISE_BIT];
   assign noise_filter_enable_out = (state_reg.phase != PH_STOPPED);

endmodule

// ===== verification/vfd_mode_asserts.sv
`timescale 1ns/1ps
module vfd_mode_asserts
   import vfd_ctrl_pkg::*;
#(parameter int NUM_OUTPUTS = NUM_OUTPUTS_DEF) (
   // Clock, reset, bus
   input wire logic        clk_in,
   input wire logic        sys_rst_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic        avs_waitrequest_out,
   // Display side
   input wire logic [15:0] grid_out,
   input wire logic        segment_window_out,
   input wire logic        scan_phase_flag_out,
   input wire logic        key_scan_start_out,
   input wire logic        display_active_out,
   input wire logic        mode_select_bit_out,
   input wire logic [5:0]  digit_outputs_out,
   input wire logic [5:0]  segment_outputs_out,
   input wire logic        noise_filter_enable_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // Slot length judged when the flag drops
   logic [11:0] scan_len_reg;
   always_ff @(posedge clk_in) begin
      if (sys_rst_in || !scan_phase_flag_out) begin
         scan_len_reg <= 12'h000;
      end else begin
         scan_len_reg <= scan_len_reg + 12'h001;
      end
   end
   sequence s_answer;
      avs_waitrequest_out ##1 !avs_waitrequest_out;
   endsequence
   a_bus_answer: assert property ($rose(avs_read_in || avs_write_in) |-> s_answer)
      else $error("bus answer late");
   a_reset_clear: assert property ($fell(sys_rst_in) |-> !display_active_out && digit_outputs_out == 6'h00)
      else $error("outputs not clear after reset");
   a_scan_len: assert property ($fell(scan_phase_flag_out) |-> scan_len_reg inside {12'h400, 12'h800})
      else $error("key scan slot length wrong");
   a_key_pulse: assert property (key_scan_start_out |=> !key_scan_start_out)
      else $error("key scan start too long");
   a_key_flag: assert property ($rose(scan_phase_flag_out) |-> key_scan_start_out)
      else $error("flag rose without start pulse");
   a_noise_follow: assert property (noise_filter_enable_out == (digit_outputs_out != 6'h00))
      else $error("noise filter enable wrong");
   a_grid_mode: assert property (grid_out != 16'h0000 |-> !$past(mode_select_bit_out) && $onehot(grid_out))
      else $error("grid driven wrongly");
   a_out_budget: assert property ({1'b0, digit_outputs_out} + {1'b0, segment_outputs_out} <= 7'(NUM_OUTPUTS))
      else $error("outputs over budget");
   a_stop_quiet: assert property ($fell(display_active_out) |-> ##[0:2] grid_out == 16'h0000)
      else $error("grid alive after stop");
endmodule

// ===== verification/vfd_panel_model.sv
`timescale 1ns/1ps
module vfd_panel_model (
   // Panel drive
   input  wire logic        clk_in,
   input  wire logic [15:0] grid_in,
   input  wire logic        window_in,
   // Lit time of the last digit
   output int               lit_cycles_out
);
   int run = 0;
   // digit lit only inside the window
   always @(posedge clk_in) begin
      if (window_in && grid_in != 16'h0000) begin
         run <= run + 1;
      end else begin
         if (run != 0) lit_cycles_out <= run;
         run <= 0;
      end
   end
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb;
   import vfd_ctrl_pkg::*;
   localparam logic [17:0] AM = {MODE_SELECT_IDX, 2'b00};
   localparam logic [17:0] AD = {DIGIT_CUT_IDX, 2'b00};
   localparam logic [17:0] AK = {MASK_COUNT_IDX, 2'b00};
   logic        clk_in, sys_rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
   logic [17:0] avs_address_in = 18'h00000;
   logic [31:0] avs_writedata_in = 32'h00000000, avs_readdata_out, q;
   logic [31:0] seed = 32'h00003507;
   logic [3:0]  avs_byteenable_in = 4'hf;
   logic [5:0]  bit_index_in = 6'h00, digit_outputs_out, segment_outputs_out;
   logic [15:0] grid_out;
   logic [4:0]  slot_index_out;
   logic [7:0]  v, m;
   logic        avs_waitrequest_out, bit_protected_out, segment_window_out, scan_phase_flag_out;
   logic        key_scan_start_out, display_active_out, mode_select_bit_out;
   logic        noise_filter_range_out, noise_filter_enable_out;
   int          mismatches = 0, comparisons = 0, lit, n;
   vfd_display_mode_control #(.NUM_OUTPUTS(53)) dut_u (.clk_in, .sys_rst_in, .avs_address_in, .avs_read_in,
      .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
      .bit_index_in, .bit_protected_out, .grid_out, .slot_index_out, .segment_window_out,
      .scan_phase_flag_out, .key_scan_start_out, .display_active_out, .mode_select_bit_out,
      .digit_outputs_out, .segment_outputs_out, .noise_filter_range_out, .noise_filter_enable_out);
   vfd_panel_model panel_u (.clk_in, .grid_in(grid_out), .window_in(segment_window_out), .lit_cycles_out(lit));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic int win_exp(input int cut, input logic cyc);
      int len;
      len = cyc ? int'(CYCLE_LONG) : int'(CYCLE_SHORT);
      return len - 2 * (((cut == 0) ? 1 : 2 * cut) * len / 32);
   endfunction
   function automatic logic [5:0] seg_exp(input logic [4:0] s, input logic [3:0] d);
      return (int'(s) + 9 < 52 - int'(d)) ? 6'(s + 9) : 6'(52 - d);
   endfunction
   task automatic complete_run();
      if (mismatches == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
      int k;
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= {24'h000000, d};
      avs_write_in <= w;
      avs_read_in <= !w;
      k = 0;
      // Answer sampled on the rising edge, before the design updates
      do begin @(posedge clk_in); k++; end while (avs_waitrequest_out !== 1'b0 && k < 40);
      q = avs_readdata_out;
      if (avs_waitrequest_out !== 1'b0) begin mismatches++; complete_run(); end
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic wait_ks();
      n = 0;
      do begin @(negedge clk_in); n++; end while (key_scan_start_out !== 1'b1 && n < 40000);
      if (n >= 40000) begin mismatches++; complete_run(); end
   endtask
   // Writes land at slot 0 so no key scan slot is cut short
   task automatic cfg(input logic [7:0] d);
      @(negedge clk_in);
      if (display_active_out === 1'b1 && scan_phase_flag_out !== 1'b1) wait_ks();
      n = 0;
      while (scan_phase_flag_out !== 1'b0 && n < 4096) begin @(negedge clk_in); n++; end
      if (n >= 4096) begin mismatches++; complete_run(); end
      bus(1'b1, AD, d);
   endtask
   task automatic zero_regs();
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, AM + 18'(4 * i), 8'h00);
         `CHK("reset_read", 32'h00000000, q)
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      zero_regs();
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'hff : rnd();
         bus(1'b1, AM, v);
         bus(1'b0, AM, 8'h00);
         `CHK("mode_read", {25'h0000000, v[6:0]}, q)
         `CHK("mode_bit", v[MODE_BIT], mode_select_bit_out)
         `CHK("noise_range", v[NOISE_BIT], noise_filter_range_out)
      end
      for (int i = 0; i < 4; i++) begin
         m = rnd() % 40;
         bus(1'b1, AK, m);
         bus(1'b0, AK, 8'h00);
         `CHK("mask_read", {24'h000000, m}, q)
      end
      bus(1'b1, AK, 8'h28);
      avs_byteenable_in <= 4'he;
      bus(1'b1, AK, 8'h01);
      avs_byteenable_in <= 4'hf;
      bus(1'b0, AK, 8'h00);
      `CHK("mask_keep", {24'h000000, m}, q)
      // fast main clock, so the noise range bit stays 0 before display
      // watch clock select lies outside; a fast main clock needs no change
      for (int i = 0; i < 2; i++) begin
         v = (i == 0) ? 8'hff : rnd();
         bus(1'b1, AM, {3'b000, v[4:0]});
         bus(1'b1, AD, {v[7:4] | 4'h1, 4'h0});
         repeat (3) @(negedge clk_in);
         `CHK("segments", seg_exp(v[4:0], v[7:4] | 4'h1), segment_outputs_out)
         `CHK("digits", 6'(v[7:4] | 4'h1) + 6'h01, digit_outputs_out)
      end
      bus(1'b1, AD, 8'h00);
      repeat (3) @(negedge clk_in);
      `CHK("stopped", 1'b0, display_active_out)
      // short cycle with cut widths 0 to 6, long cycle with cut 7 last
      for (int k = 0; k < 8; k++) begin
         cfg({4'h1, 3'(k), k == 7});
         wait_ks();
         wait_ks();
         `CHK("period", 3 * ((k == 7) ? 2048 : 1024), n)
         `CHK("lit", win_exp(k, k == 7), lit)
         `CHK("ks_slot", 5'h02, slot_index_out)
         bus(1'b0, AM, 8'h00);
         `CHK("scan_flag", 1'b1, q[SCAN_FLAG_BIT])
      end
      v = rnd();
      // mask count kept below the output total
      m = 8'(1 + int'(rnd()) % (int'(v[4:0]) + 8));
      bus(1'b1, AM, {3'b001, v[4:0]});
      bus(1'b1, AK, m);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) bus(1'b1, AM, {3'b000, v[4:0]});
         bit_index_in <= 6'(m - 8'h01 + 8'(i % 2));
         repeat (2) @(negedge clk_in);
         `CHK("protect", i == 0, bit_protected_out)
         @(posedge clk_in);
      end
      cfg(8'h1f);
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      zero_regs();
      `CHK("reset_idle", 1'b0, display_active_out)
      complete_run();
   end
endmodule
bind vfd_display_mode_control vfd_mode_asserts #(.NUM_OUTPUTS(NUM_OUTPUTS)) chk_u (.clk_in, .sys_rst_in,
   .avs_read_in, .avs_write_in, .avs_waitrequest_out, .grid_out, .segment_window_out, .scan_phase_flag_out,
   .key_scan_start_out, .display_active_out, .mode_select_bit_out, .digit_outputs_out,
   .segment_outputs_out, .noise_filter_enable_out);
